// *** inc/sgm_pkg.sv ***
// Functional notes
// - auto-close delay is settable from 0 to 124 seconds
// - switch 1 on, fully open, inputs quiet: close when delay expires
// - max-run countdown, 15 to 100 s, restarts at every motor start
// - max-run expiry locks out and drives the emergency alarm
// - switch 2 on: warning output two seconds before start; off: only running
// - switch 3 on: single button cycles open, stop, close, stop
// - switch 3 off: single button opens, or closes when fully open
// - switch 4 off right-hand, on left-hand; sets motor direction mapping
// - switch 5 on: one second lock release before motor energises
// - switch 6 on disables the motor brake, off applies it normally
// - switch 8 off for stand-alone or master, on for slave
// - stop input is a normally closed loop; open loop stops motor
// - open input starts opening, close input starts closing
// - reverse input while closing drives gate back to fully open
// - open obstruction: stop, brief reverse, stop, disable auto-close
// - obstruction again before a limit: stop, alarm, lockout
// - close obstruction acts the same, only while closing
// - hold-open input keeps gate fully open, no closing begins
// - linked master and slave open and close together
// - open limit on right contact for right-hand, swapped for left-hand
// - current trip while closing turns the gate round toward full open without stopping
package sgm_pkg;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int PRESTART_MS = 2000;
  localparam int LOCKDLY_MS = 1000;
  localparam int BACKOFF_MS = 500;
  localparam int PRESTART_TICKS = (PRESTART_MS + TICK_MS - 1) / TICK_MS;
  localparam int LOCKDLY_TICKS = (LOCKDLY_MS + TICK_MS - 1) / TICK_MS;
  localparam int BACKOFF_TICKS = (BACKOFF_MS + TICK_MS - 1) / TICK_MS;
  localparam int TICKS_PER_SEC = 1000 / TICK_MS;

  // ****************************************************************
  // timer setting limits and reset values in seconds, and the config reset value
  // ****************************************************************
  localparam logic [6:0] ACSEC_MAX = 7'h7C;
  localparam logic [6:0] MRSEC_MIN = 7'h0F;
  localparam logic [6:0] MRSEC_MAX = 7'h64;
  localparam logic [6:0] ACSEC_RST = 7'h1E;
  localparam logic [6:0] MRSEC_RST = 7'h3C;
  localparam logic [7:0] CFG_RST = 8'h00;

  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [4:0] ADDR_CFG = 5'h00;
  localparam logic [4:0] ADDR_ACSEC = 5'h04;
  localparam logic [4:0] ADDR_MRSEC = 5'h08;
  localparam logic [4:0] ADDR_CTRL = 5'h0C;
  localparam logic [4:0] ADDR_STATUS = 5'h10;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CFG_AUTOCLOSE = 0;
  localparam int CFG_PREWARN = 1;
  localparam int CFG_SBCYCLE = 2;
  localparam int CFG_LEFTHAND = 3;
  localparam int CFG_LOCKDLY = 4;
  localparam int CFG_NOBRAKE = 5;
  localparam int CFG_SLAVE = 7;
  localparam int CTRL_CLRLOCK = 0;
  localparam int ST_LOCKOUT = 0;
  localparam int ST_ATOPEN = 1;
  localparam int ST_ATCLOSED = 2;
  localparam int ST_DIROPEN = 3;
  localparam int ST_STRIKE = 4;
  localparam int ST_ACDIS = 5;
  localparam int ST_RUNNING = 6;
  localparam int ST_STATE = 8;

  typedef enum logic [2:0] {
    SGM_IDLE,
    SGM_PRESTART,
    SGM_RUN,
    SGM_BACKOFF,
    SGM_LOCKOUT
  } sgmState_t;

endpackage

// *** src/sgm_gate_ctrl.sv ***
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module sgm_gate_ctrl
  import sgm_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic [4:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitrequest,
  input wire logic openIn,
  input wire logic closeIn,
  input wire logic stopLoopClosed,
  input wire logic singleIn,
  input wire logic reverseIn,
  input wire logic obstOpenIn,
  input wire logic obstCloseIn,
  input wire logic holdOpenIn,
  input wire logic limitRight,
  input wire logic limitLeft,
  input wire logic currentTripIn,
  input wire logic linkOpenIn,
  input wire logic linkCloseIn,
  output logic motorRun,
  output logic motorFwd,
  output logic brake,
  output logic warnOut,
  output logic lockRelease,
  output logic emergencyAlarm,
  output logic linkOpenOut,
  output logic linkCloseOut
);

  localparam int PW = $clog2(TICK_CYC) + 1;

  initial begin
    if (TICK_CYC < 1) begin
      $error("TICK_CYC must be at least one");
    end
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    sgmState_t st;
    logic dirOpen;
    logic atOpen;
    logic atClosed;
    logic strike;
    logic acDis;
    logic [1:0] sbPhase;
    logic sbPrev;
    logic [PW-1:0] tickDiv;
    logic tick;
    logic [10:0] seqCnt;
    logic [10:0] runCnt;
    logic [10:0] acCnt;
    logic [7:0] cfg;
    logic [6:0] acSec;
    logic [6:0] mrSec;
    logic waitReq;
    logic [31:0] readData;
    logic motorRun;
    logic motorFwd;
    logic brake;
    logic warn;
    logic lockRel;
    logic alarm;
    logic linkOpen;
    logic linkClose;
  } sgmRegs_t;

  sgmRegs_t r;
  sgmRegs_t n;

  logic openLim;
  logic closeLim;
  logic slave;
  logic eOpen;
  logic eClose;
  logic sbPress;
  logic startOpen;
  logic startClose;
  logic fromCmd;
  logic running;
  logic wrHit;
  logic [7:0] wrByte;
  logic [10:0] acLen;
  logic [10:0] mrLen;
  logic [10:0] preLen;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    n = r;
    startOpen = 1'b0;
    startClose = 1'b0;
    fromCmd = 1'b0;
    // limit contacts follow the hand of operation
    openLim = r.cfg[CFG_LEFTHAND] ? limitLeft : limitRight;
    closeLim = r.cfg[CFG_LEFTHAND] ? limitRight : limitLeft;
    slave = r.cfg[CFG_SLAVE];
    // a slave also takes commands from the master link
    eOpen = openIn | (slave & linkOpenIn);
    eClose = closeIn | (slave & linkCloseIn);
    sbPress = singleIn & ~r.sbPrev;
    n.sbPrev = singleIn;
    acLen = 11'(r.acSec) * 11'(TICKS_PER_SEC);
    mrLen = 11'(r.mrSec) * 11'(TICKS_PER_SEC);
    if (r.cfg[CFG_PREWARN]) begin
      preLen = 11'(PRESTART_TICKS);
    end else if (r.cfg[CFG_LOCKDLY]) begin
      preLen = 11'(LOCKDLY_TICKS);
    end else begin
      preLen = 11'h000;
    end

    // tenth-second prescaler
    n.tick = 1'b0;
    if (r.tickDiv == '0) begin
      n.tickDiv = PW'(TICK_CYC - 1);
      n.tick = 1'b1;
    end else begin
      n.tickDiv = r.tickDiv - 1'b1;
    end

    // bus slave: one wait cycle, then answer
    wrHit = avsWrite & ~r.waitReq & avsByteEnable[0];
    wrByte = avsWriteData[7:0];
    n.waitReq = 1'b1;
    if ((avsRead | avsWrite) & r.waitReq) begin
      n.waitReq = 1'b0;
      n.readData = 32'h0000_0000;
      unique case (avsAddress)
        ADDR_CFG: n.readData[7:0] = r.cfg;
        ADDR_ACSEC: n.readData[6:0] = r.acSec;
        ADDR_MRSEC: n.readData[6:0] = r.mrSec;
        ADDR_STATUS: begin
          n.readData[ST_LOCKOUT] = r.st == SGM_LOCKOUT;
          n.readData[ST_ATOPEN] = r.atOpen;
          n.readData[ST_ATCLOSED] = r.atClosed;
          n.readData[ST_DIROPEN] = r.dirOpen;
          n.readData[ST_STRIKE] = r.strike;
          n.readData[ST_ACDIS] = r.acDis;
          n.readData[ST_RUNNING] = r.motorRun;
          n.readData[ST_STATE +: 3] = r.st;
        end
        default: n.readData = 32'h0000_0000;
      endcase
    end
    if (wrHit) begin
      unique case (avsAddress)
        ADDR_CFG: n.cfg = avsWriteData[7:0];
        ADDR_ACSEC: begin
          // whole byte is clamped so that a high bit cannot wrap
          n.acSec = (wrByte > 8'(ACSEC_MAX)) ? ACSEC_MAX : wrByte[6:0];
        end
        ADDR_MRSEC: begin
          if (wrByte < 8'(MRSEC_MIN)) begin
            n.acSec = r.acSec;
            n.mrSec = MRSEC_MIN;
          end else if (wrByte > 8'(MRSEC_MAX)) begin
            n.mrSec = MRSEC_MAX;
          end else begin
            n.mrSec = wrByte[6:0];
          end
        end
        default: n.cfg = r.cfg;
      endcase
    end

    // gate sequencer
    unique case (r.st)
      SGM_IDLE: begin
        n.acCnt = 11'h000;
        if (!stopLoopClosed) begin
          n.acCnt = 11'h000;
        end else if (eOpen && !r.atOpen) begin
          startOpen = 1'b1;
          fromCmd = 1'b1;
        end else if (eClose && !r.atClosed && !holdOpenIn) begin
          startClose = 1'b1;
          fromCmd = 1'b1;
        end else if (sbPress && r.cfg[CFG_SBCYCLE]) begin
          // open, stop, close, stop
          n.sbPhase = r.sbPhase + 2'h1;
          if (r.sbPhase == 2'h0) begin
            startOpen = !r.atOpen;
          end else if (r.sbPhase == 2'h2) begin
            startClose = !r.atClosed && !holdOpenIn;
          end
          fromCmd = 1'b1;
        end else if (sbPress) begin
          startOpen = !r.atOpen;
          startClose = r.atOpen && !holdOpenIn;
          fromCmd = 1'b1;
        end else if (r.cfg[CFG_AUTOCLOSE] && r.atOpen && !r.acDis &&
                     !eOpen && !reverseIn && !obstOpenIn &&
                     !obstCloseIn && !holdOpenIn) begin
          // count quiet time at full open
          if (r.acCnt >= acLen) begin
            startClose = 1'b1;
          end else if (r.tick) begin
            n.acCnt = r.acCnt + 11'h001;
          end else begin
            n.acCnt = r.acCnt;
          end
        end
      end
      SGM_PRESTART: begin
        if (!stopLoopClosed) begin
          n.st = SGM_IDLE;
        end else if (r.seqCnt == 11'h000) begin
          n.st = SGM_RUN;
          n.runCnt = mrLen;
        end else if (r.tick) begin
          n.seqCnt = r.seqCnt - 11'h001;
        end
      end
      SGM_RUN: begin
        if (!stopLoopClosed) begin
          n.st = SGM_IDLE;
        end else if (r.dirOpen && openLim) begin
          n.st = SGM_IDLE;
          n.atOpen = 1'b1;
          n.strike = 1'b0;
        end else if (!r.dirOpen && closeLim) begin
          n.st = SGM_IDLE;
          n.atClosed = 1'b1;
          n.strike = 1'b0;
        end else if ((r.dirOpen && obstOpenIn) ||
                     (!r.dirOpen && obstCloseIn)) begin
          if (r.strike) begin
            n.st = SGM_LOCKOUT;
          end else begin
            n.st = SGM_BACKOFF;
            n.strike = 1'b1;
            n.acDis = 1'b1;
            n.dirOpen = !r.dirOpen;
            // one tick at rest before backing off
            n.seqCnt = 11'(BACKOFF_TICKS + 1);
          end
        end else if (r.runCnt == 11'h000) begin
          n.st = SGM_LOCKOUT;
        end else if (!r.dirOpen && (reverseIn || currentTripIn ||
                     holdOpenIn || eOpen)) begin
          // turn round toward full open
          n.dirOpen = 1'b1;
          n.runCnt = mrLen;
        end else if (sbPress && r.cfg[CFG_SBCYCLE]) begin
          n.st = SGM_IDLE;
          n.sbPhase = r.sbPhase + 2'h1;
        end else if (sbPress && !r.dirOpen) begin
          n.dirOpen = 1'b1;
          n.runCnt = mrLen;
        end else if (r.tick) begin
          n.runCnt = r.runCnt - 11'h001;
        end
      end
      SGM_BACKOFF: begin
        if (!stopLoopClosed || r.seqCnt == 11'h000) begin
          n.st = SGM_IDLE;
        end else if (r.tick) begin
          n.seqCnt = r.seqCnt - 11'h001;
        end
      end
      SGM_LOCKOUT: begin
        if (wrHit && avsAddress == ADDR_CTRL &&
            avsWriteData[CTRL_CLRLOCK]) begin
          n.st = SGM_IDLE;
          n.strike = 1'b0;
        end
      end
      default: n.st = SGM_LOCKOUT;
    endcase

    // common start of travel
    if (startOpen || startClose) begin
      n.st = SGM_PRESTART;
      n.dirOpen = startOpen;
      n.seqCnt = preLen;
      n.atOpen = 1'b0;
      n.atClosed = 1'b0;
      n.acCnt = 11'h000;
      if (fromCmd) begin
        n.acDis = 1'b0;
      end
    end

    // outputs from next state
    running = (n.st == SGM_RUN) ||
              (n.st == SGM_BACKOFF &&
               n.seqCnt <= 11'(BACKOFF_TICKS));
    n.motorRun = running;
    n.motorFwd = n.dirOpen ^ r.cfg[CFG_LEFTHAND];
    n.brake = !running && !r.cfg[CFG_NOBRAKE];
    n.warn = running ||
             (n.st == SGM_PRESTART && r.cfg[CFG_PREWARN]);
    n.lockRel = r.cfg[CFG_LOCKDLY] && (running ||
                (n.st == SGM_PRESTART &&
                 n.seqCnt <= 11'(LOCKDLY_TICKS)));
    n.alarm = n.st == SGM_LOCKOUT;
    n.linkOpen = !slave && n.st == SGM_RUN && n.dirOpen;
    n.linkClose = !slave && n.st == SGM_RUN && !n.dirOpen;
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      r <= '0;
      r.st <= SGM_IDLE;
      r.cfg <= CFG_RST;
      r.acSec <= ACSEC_RST;
      r.mrSec <= MRSEC_RST;
      r.waitReq <= 1'b1;
      r.brake <= 1'b1;
    end else if (clkEn) begin
      r <= n;
    end
  end

  // outputs straight from the state register
  assign avsReadData = r.readData;
  assign avsWaitrequest = r.waitReq;
  assign motorRun = r.motorRun;
  assign motorFwd = r.motorFwd;
  assign brake = r.brake;
  assign warnOut = r.warn;
  assign lockRelease = r.lockRel;
  assign emergencyAlarm = r.alarm;
  assign linkOpenOut = r.linkOpen;
  assign linkCloseOut = r.linkClose;

endmodule

// *** dv/sgm_gate_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// gate travel and limit contacts
// ****************************************************************
module sgm_gate_model #(
  parameter int TRAVEL = 300
) (
  input wire logic clk_sys,
  input wire logic motorRun,
  input wire logic motorFwd,
  input wire logic leftHand,
  input wire logic stall,
  output logic limitRight,
  output logic limitLeft
);
  int pos = 150;
  logic openDir;
  logic atOpen;
  logic atShut;
  // forward turns the gate open on a right-hand unit
  assign openDir = motorFwd ^ leftHand;
  // position follows the motor unless the gate is jammed
  always @(posedge clk_sys) begin
    if (motorRun && !stall) begin
      if (openDir && pos < TRAVEL) pos <= pos + 1;
      else if (!openDir && pos > 0) pos <= pos - 1;
    end
  end
  // contacts close at the travel ends, swapped by hand
  assign atOpen = (pos >= TRAVEL);
  assign atShut = (pos <= 0);
  assign limitRight = leftHand ? atShut : atOpen;
  assign limitLeft = leftHand ? atOpen : atShut;
endmodule

// *** dv/sgm_ctrl_monitor.sv ***
`timescale 1ns/1ps
// ****************************************************************
// port checker
// ****************************************************************
module sgm_ctrl_monitor (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic avsWaitrequest,
  input wire logic stopLoopClosed,
  input wire logic reverseIn,
  input wire logic holdOpenIn,
  input wire logic motorRun,
  input wire logic brake,
  input wire logic warnOut,
  input wire logic emergencyAlarm,
  input wire logic linkCloseOut
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // bus request taken, then one answer cycle
  sequence s_taken;
    (avsRead || avsWrite) && avsWaitrequest && clkEn;
  endsequence
  sequence s_answer;
    !avsWaitrequest ##1 avsWaitrequest;
  endsequence
  a_bus_answer:
    assert property (s_taken |=> s_answer) else $error("bus answer late");
  a_stop_halts:
    assert property (!stopLoopClosed [*3] |-> !motorRun)
      else $error("motor runs with stop loop open");
  a_brake_free:
    assert property (motorRun |-> !brake) else $error("brake while running");
  a_alarm_still:
    assert property (emergencyAlarm |-> !motorRun)
      else $error("motor runs in lockout");
  a_warn_running:
    assert property (motorRun |-> warnOut) else $error("warning off in run");
  a_hold_open:
    assert property (holdOpenIn [*3] |-> !linkCloseOut)
      else $error("closing while held open");
  a_reverse_stops:
    assert property (reverseIn && linkCloseOut && stopLoopClosed
      |-> ##[1:4] !linkCloseOut) else $error("reverse ignored");
  a_lock_sticks:
    assert property ($fell(emergencyAlarm)
      |-> $past(avsWrite) || $past(avsWrite, 2))
      else $error("lockout left without a write");
endmodule
bind sgm_gate_ctrl sgm_ctrl_monitor i_mon (
  .clk_sys, .nrst, .clkEn, .avsRead, .avsWrite, .avsWaitrequest,
  .stopLoopClosed, .reverseIn, .holdOpenIn, .motorRun, .brake,
  .warnOut, .emergencyAlarm, .linkCloseOut
);

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`define CHK(a, e) begin \
  n_compared++; \
  if ((a) !== (e)) begin \
    n_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); \
  end \
end
module testbench
  import sgm_pkg::*;
;
  localparam int TK = 10;
  localparam int PRE_CYC = PRESTART_TICKS * TK;
  localparam int LCK_CYC = LOCKDLY_TICKS * TK;
  localparam int MR_CYC = int'(MRSEC_MIN) * TICKS_PER_SEC * TK;
  logic clk_sys = 1'h0;
  logic nrst = 1'h0;
  logic [4:0] avsAddress = 5'h00;
  logic avsRead = 1'h0;
  logic avsWrite = 1'h0;
  logic [31:0] avsWriteData = 32'h0;
  logic [3:0] avsByteEnable = 4'h0;
  logic [31:0] avsReadData, rdv;
  logic avsWaitrequest, limitRight, limitLeft, motorRun, motorFwd, brake;
  logic warnOut, lockRelease, emergencyAlarm;
  logic openIn = 1'h0, closeIn = 1'h0, singleIn = 1'h0, reverseIn = 1'h0;
  logic obstCloseIn = 1'h0, holdOpenIn = 1'h0, stall = 1'h0;
  logic obstOpenIn = 1'h0, currentTripIn = 1'h0;
  logic linkOpenIn = 1'h0, linkCloseIn = 1'h0;
  logic linkOpenOut, linkCloseOut;
  logic stopLoopClosed = 1'h1;
  logic leftHand = 1'h0;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  int cnt;
  // ****************************************************************
  // design and gate
  // ****************************************************************
  sgm_gate_ctrl #(.TICK_CYC(TK)) i_dut (
    .clk_sys, .nrst, .clkEn(1'h1), .avsAddress, .avsRead, .avsWrite,
    .avsWriteData, .avsByteEnable, .avsReadData, .avsWaitrequest,
    .openIn, .closeIn, .stopLoopClosed, .singleIn, .reverseIn,
    .obstOpenIn, .obstCloseIn, .holdOpenIn, .limitRight, .limitLeft,
    .currentTripIn, .linkOpenIn, .linkCloseIn,
    .motorRun, .motorFwd, .brake, .warnOut, .lockRelease, .emergencyAlarm,
    .linkOpenOut, .linkCloseOut
  );
  sgm_gate_model i_gate (
    .clk_sys, .motorRun, .motorFwd, .leftHand, .stall, .limitRight,
    .limitLeft
  );
  // ****************************************************************
  // clock, timeout and tasks
  // ****************************************************************
  always #10 clk_sys = ~clk_sys;
  // cut a hung run short
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one bus access held until waitrequest is sampled low
  task automatic bus(logic w, logic [4:0] a, logic [7:0] d);
    int k;
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWriteData <= {24'h0, d};
    avsByteEnable <= 4'h1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avsWaitrequest !== 1'h0 && k < 40);
    rdv = avsReadData;
    avsRead <= 1'h0;
    avsWrite <= 1'h0;
    `CHK(avsWaitrequest, 1'h0)
    @(posedge clk_sys);
  endtask
  task automatic rdc(logic [4:0] a, logic [31:0] e, logic [31:0] m);
    bus(1'h0, a, 8'h00);
    `CHK(rdv & m, e)
  endtask
  task automatic cfg(logic [7:0] v);
    bus(1'h1, ADDR_CFG, v);
    leftHand <= v[CFG_LEFTHAND];
  endtask
  function automatic logic sel(int s);
    case (s)
      0: return motorRun;
      1: return warnOut;
      2: return lockRelease;
      default: return emergencyAlarm;
    endcase
  endfunction
  // wait for an output level, counting cycles
  task automatic wt(int s, logic v, int lim);
    cnt = 0;
    while (sel(s) !== v && cnt < lim) begin
      @(posedge clk_sys);
      cnt++;
    end
    `CHK(sel(s), v)
  endtask
  // one-cycle contact pulse
  task automatic pulse(int s);
    case (s)
      0: openIn <= 1'h1;
      1: closeIn <= 1'h1;
      2: singleIn <= 1'h1;
      3: reverseIn <= 1'h1;
      4: obstCloseIn <= 1'h1;
      5: currentTripIn <= 1'h1;
      6: obstOpenIn <= 1'h1;
      7: linkOpenIn <= 1'h1;
      default: linkCloseIn <= 1'h1;
    endcase
    @(posedge clk_sys);
    {openIn, closeIn, singleIn, reverseIn, obstCloseIn} <= 5'h00;
    {currentTripIn, obstOpenIn, linkOpenIn, linkCloseIn} <= 4'h0;
    @(posedge clk_sys);
  endtask
  // full run in one direction, checking direction and end position
  task automatic run(int s, logic fwd, logic [31:0] st);
    pulse(s);
    wt(0, 1'h1, 300);
    `CHK(motorFwd, fwd)
    wt(0, 1'h0, 400);
    rdc(ADDR_STATUS, st, 32'h747);
  endtask
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (5) @(posedge clk_sys);
    nrst <= 1'h1;
    @(posedge clk_sys);
    rdc(ADDR_CFG, 32'h0, 32'hFFFFFFFF);
    rdc(ADDR_ACSEC, 32'h1E, 32'hFFFFFFFF);
    rdc(ADDR_MRSEC, 32'h3C, 32'hFFFFFFFF);
    rdc(5'h14, 32'h0, 32'hFFFFFFFF);
    `CHK(brake, 1'h1)
    $display("test reset done");
    run(0, 1'h1, 32'h2);
    run(2, 1'h0, 32'h4);
    cfg(8'h08);
    run(0, 1'h0, 32'h2);
    run(1, 1'h1, 32'h4);
    $display("test hand done");
    cfg(8'h02);
    pulse(0);
    wt(1, 1'h1, 50);
    wt(0, 1'h1, 400);
    `CHK(cnt >= PRE_CYC - TK + 2 && cnt <= PRE_CYC + 1, 1'h1)
    wt(0, 1'h0, 400);
    cfg(8'h10);
    pulse(1);
    wt(2, 1'h1, 50);
    wt(0, 1'h1, 300);
    `CHK(cnt >= LCK_CYC - TK + 2 && cnt <= LCK_CYC + 1, 1'h1)
    wt(0, 1'h0, 400);
    cfg(8'h20);
    @(posedge clk_sys);
    `CHK(brake, 1'h0)
    $display("test options done");
    cfg(8'h00);
    pulse(0);
    wt(0, 1'h1, 50);
    repeat (20) @(posedge clk_sys);
    stopLoopClosed <= 1'h0;
    repeat (3) @(posedge clk_sys);
    `CHK(motorRun, 1'h0)
    stopLoopClosed <= 1'h1;
    run(0, 1'h1, 32'h2);
    bus(1'h1, ADDR_ACSEC, 8'hFF);
    rdc(ADDR_ACSEC, 32'h7C, 32'hFFFFFFFF);
    bus(1'h1, ADDR_ACSEC, 8'h01);
    holdOpenIn <= 1'h1;
    cfg(8'h01);
    repeat (250) @(posedge clk_sys);
    `CHK(motorRun, 1'h0)
    holdOpenIn <= 1'h0;
    wt(0, 1'h1, 200);
    `CHK(motorFwd, 1'h0)
    repeat (30) @(posedge clk_sys);
    pulse(3);
    repeat (3) @(posedge clk_sys);
    `CHK(motorFwd, 1'h1)
    wt(0, 1'h0, 400);
    cfg(8'h00);
    $display("test timers done");
    run(1, 1'h0, 32'h4);
    pulse(0);
    wt(0, 1'h1, 50);
    repeat (30) @(posedge clk_sys);
    pulse(1);
    `CHK(motorFwd, 1'h1)
    pulse(4);
    `CHK(motorRun, 1'h1)
    wt(0, 1'h0, 400);
    pulse(1);
    wt(0, 1'h1, 50);
    repeat (20) @(posedge clk_sys);
    pulse(4);
    wt(0, 1'h0, 10);
    wt(0, 1'h1, 20);
    `CHK(motorFwd, 1'h1)
    wt(0, 1'h0, 100);
    rdc(ADDR_STATUS, 32'h30, 32'h30);
    pulse(1);
    wt(0, 1'h1, 50);
    repeat (10) @(posedge clk_sys);
    pulse(4);
    wt(3, 1'h1, 20);
    rdc(ADDR_STATUS, 32'h401, 32'h701);
    pulse(0);
    `CHK(motorRun, 1'h0)
    bus(1'h1, ADDR_CTRL, 8'h01);
    rdc(ADDR_STATUS, 32'h0, 32'h701);
    $display("test obstruction done");
    bus(1'h1, ADDR_MRSEC, 8'h05);
    rdc(ADDR_MRSEC, 32'h0F, 32'hFFFFFFFF);
    stall <= 1'h1;
    pulse(0);
    wt(0, 1'h1, 50);
    wt(3, 1'h1, 1700);
    `CHK(cnt >= MR_CYC - TK + 2 && cnt <= MR_CYC + 1, 1'h1)
    `CHK(motorRun, 1'h0)
    $display("test max run done");
    stall <= 1'h0;
    bus(1'h1, ADDR_CTRL, 8'h01);
    bus(1'h1, ADDR_MRSEC, 8'h3C);
    pulse(1);
    wt(0, 1'h1, 50);
    `CHK(linkCloseOut, 1'h1)
    pulse(5);
    `CHK(motorFwd, 1'h1)
    `CHK(linkOpenOut, 1'h1)
    pulse(6);
    wt(0, 1'h0, 10);
    wt(0, 1'h1, 20);
    `CHK(motorFwd, 1'h0)
    wt(0, 1'h0, 100);
    rdc(ADDR_STATUS, 32'h30, 32'h30);
    cfg(8'h04);
    pulse(2);
    wt(0, 1'h1, 50);
    `CHK(motorFwd, 1'h1)
    pulse(2);
    wt(0, 1'h0, 10);
    pulse(2);
    wt(0, 1'h1, 50);
    `CHK(motorFwd, 1'h0)
    pulse(2);
    wt(0, 1'h0, 10);
    cfg(8'h80);
    pulse(7);
    wt(0, 1'h1, 50);
    `CHK(motorFwd, 1'h1)
    `CHK(linkOpenOut, 1'h0)
    wt(0, 1'h0, 400);
    pulse(8);
    wt(0, 1'h1, 50);
    `CHK(motorFwd, 1'h0)
    wt(0, 1'h0, 400);
    cfg(8'h00);
    $display("test links done");
    final_report();
  end
endmodule
